// [design/diag_sense_pkg.sv]
package diag_sense_pkg;

    // ****************************************
    // frame layout of the 16-bit command word
    // ****************************************
    localparam int          FRM_WR_BIT     = 15;
    localparam int          FRM_BANK_BIT   = 14;
    localparam int          FRM_ADDR_LSB   = 10;
    localparam int          DATA_W         = 10;
    localparam int          NUM_CH         = 4;

    // ****************************************
    // register addresses (bank bit set)
    // ****************************************
    localparam logic        REG_BANK       = 1'b1;
    localparam logic [3:0]  ADDR_IN_DRIVE  = 4'h1;
    localparam logic [3:0]  ADDR_DIAG_CTRL = 4'h3;
    localparam logic [1:0]  ADDR_CHAN_HI   = 2'h3;

    // ****************************************
    // field positions
    // ****************************************
    localparam int          MUX_LSB        = 0;
    localparam int          SRC_ON_BIT     = 3;
    localparam int          BYPASS_BIT     = 3;
    localparam int          AUTO_BIT       = 4;
    localparam int          COMPAT_BIT     = 0;
    localparam int          LEVEL_BIT      = 1;
    localparam int          SYDEL_LSB      = 2;
    localparam int          FRAME_LIMP_BIT = 14;
    localparam int          FRAME_BYP_BIT  = 13;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [2:0]  MUX_RST        = 3'h6;
    localparam logic        SRC_ON_RST     = 1'b0;
    localparam logic        AUTO_RST       = 1'b0;
    localparam logic        COMPAT_RST     = 1'b0;
    localparam logic        LEVEL_RST      = 1'b0;
    localparam logic [1:0]  SYDEL_RST      = 2'h0;

    // ****************************************
    // sync delay: step of 8 reference periods, 24 at most
    // ****************************************
    localparam int          SYNC_STEP      = 8;
    localparam int          SYNC_TAPS      = 3 * SYNC_STEP;

    typedef enum logic [2:0] {
        ROUTE_CH0  = 3'b000,
        ROUTE_CH1  = 3'b001,
        ROUTE_CH2  = 3'b010,
        ROUTE_CH3  = 3'b011,
        ROUTE_EXT0 = 3'b100,
        ROUTE_EXT1 = 3'b101,
        ROUTE_HIZ  = 3'b110,
        ROUTE_STBY = 3'b111
    } route_t;

    typedef struct packed {
        logic [SYNC_TAPS-1:0] line;
        logic                 out;
    } sync_state_t;

    typedef struct packed {
        route_t                 sense_route_select;
        logic                   src_on;
        logic                   auto_sw;
        logic                   compat;
        logic                   level;
        logic [NUM_CH-1:0][1:0] sydel;
        logic [DATA_W-1:0]      rd_data;
        logic                   rd_valid;
        logic [15:0]            diag;
        logic                   sense_drive;
        logic [1:0]             sense_chan;
        logic                   standby;
        logic                   ext_drv_diag_en0;
        logic                   ext_drv_diag_en1;
    } main_state_t;

endpackage

// [design/sync_delay.sv]
`timescale 1ns/100ps
module sync_delay
    import diag_sense_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       step_en,
    input  wire logic       sync_in,
    input  wire logic [1:0] sel,
    output logic            sync_out
);

    sync_state_t r;
    sync_state_t n;

    // delay line advances once per reference period, tap chosen by sel
    always_comb begin
        n = r;
        if (step_en) begin
            n.line = {r.line[SYNC_TAPS-2:0], sync_in};
        end
        case (sel)
            2'h0:    n.out = sync_in;
            2'h1:    n.out = r.line[SYNC_STEP-1];
            2'h2:    n.out = r.line[2*SYNC_STEP-1];
            2'h3:    n.out = r.line[3*SYNC_STEP-1];
            default: n.out = 1'b0;
        endcase
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign sync_out = r.out;

    // ****************************************
    // checks
    // ****************************************
    tap_longest_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (sel == 2'h3) |=> (sync_out == $past(r.line[SYNC_TAPS-1])))
        else $error("sync delay 24 tap not selected");

endmodule

// [design/diag_sense_ctrl.sv]
`timescale 1ns/100ps
module diag_sense_ctrl
    import diag_sense_pkg::*;
(
    input  wire logic              CLK,
    input  wire logic              NRST,
    input  wire logic              FRAME_VALID,
    input  wire logic [15:0]       FRAME_WORD,
    input  wire logic [NUM_CH-1:0] CHAN_ON,
    input  wire logic              BYPASS_HIGH,
    input  wire logic [NUM_CH-1:0] CHAN_FAULT,
    input  wire logic              LIMP_HOME,
    input  wire logic              AUTO_PWM_RUN,
    input  wire logic [1:0]        AUTO_ROUTE_SEL,
    input  wire logic              PWM_CLK_EN,
    input  wire logic [NUM_CH-1:0] SYNC_IN,
    output logic [DATA_W-1:0]      RD_DATA,
    output logic                   RD_VALID,
    output logic [15:0]            DIAG_FRAME,
    output logic                   SENSE_DRIVE,
    output logic [1:0]             SENSE_CHAN,
    output logic                   SENSE_STANDBY,
    output logic                   EXT_DRV_DIAG_EN0,
    output logic                   EXT_DRV_DIAG_EN1,
    output logic                   OPEN_LOAD_SOURCE_ON,
    output logic                   SOURCE_LEVEL_HIGH,
    output logic [NUM_CH-1:0]      SYNC_OUT
);

    // ****************************************
    // reset release
    // ****************************************
    logic [1:0] rst_pipe;
    logic       rst_n;

    // assert at once, release two clocks after NRST rises
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end

    assign rst_n = rst_pipe[1];

    // ****************************************
    // frame decode
    // ****************************************
    logic              is_wr;
    logic              our_bank;
    logic [3:0]        addr;
    logic [DATA_W-1:0] wdata;
    logic              hit_dcr;
    logic              hit_input_drive_source_config;
    logic              hit_chan;
    logic              auto_act;
    logic [2:0]        eff_sel;
    main_state_t       r;
    main_state_t       n;

    // field split of the incoming command word
    assign is_wr    = FRAME_WORD[FRM_WR_BIT];
    assign our_bank = (FRAME_WORD[FRM_BANK_BIT] == REG_BANK);
    assign addr     = FRAME_WORD[FRM_ADDR_LSB +: 4];
    assign wdata    = FRAME_WORD[DATA_W-1:0];
    assign hit_dcr  = FRAME_VALID && our_bank && (addr == ADDR_DIAG_CTRL);
    assign hit_input_drive_source_config = FRAME_VALID && our_bank && (addr == ADDR_IN_DRIVE);
    assign hit_chan = FRAME_VALID && our_bank && (addr[3:2] == ADDR_CHAN_HI);

    // the PWM generator only takes over the sense channel codes
    assign auto_act = r.auto_sw && AUTO_PWM_RUN && !r.sense_route_select[2];
    assign eff_sel  = auto_act ? {1'b0, AUTO_ROUTE_SEL} : r.sense_route_select;

    // ****************************************
    // state
    // ****************************************

    // register writes, read answers and pin decode
    always_comb begin
        n          = r;
        n.rd_valid = 1'b0;

        // writes: only the defined fields are stored
        if (is_wr) begin
            if (hit_dcr) begin
                n.sense_route_select     = route_t'(wdata[MUX_LSB +: 3]);
                n.src_on  = wdata[SRC_ON_BIT];
                n.auto_sw = wdata[AUTO_BIT];
            end
            if (hit_input_drive_source_config) begin
                n.compat  = wdata[COMPAT_BIT];
                n.level   = wdata[LEVEL_BIT];
            end
            if (hit_chan) begin
                n.sydel[addr[1:0]] = wdata[SYDEL_LSB +: 2];
            end
        end

        // reads: answer in the next cycle, unknown addresses give zero
        if (FRAME_VALID && !is_wr) begin
            n.rd_valid = 1'b1;
            n.rd_data  = '0;
            if (hit_dcr) begin
                n.rd_data[MUX_LSB +: 3] = r.sense_route_select;
                n.rd_data[BYPASS_BIT]   = BYPASS_HIGH;
                n.rd_data[AUTO_BIT]     = r.auto_sw;
            end
            if (hit_input_drive_source_config) begin
                n.rd_data[COMPAT_BIT] = r.compat;
                n.rd_data[LEVEL_BIT]  = r.level;
            end
            if (hit_chan) begin
                n.rd_data[SYDEL_LSB +: 2] = r.sydel[addr[1:0]];
            end
        end

        // diagnosis frame is refreshed every cycle
        n.diag                 = '0;
        n.diag[NUM_CH-1:0]     = CHAN_FAULT;
        n.diag[FRAME_LIMP_BIT] = LIMP_HOME;
        n.diag[FRAME_BYP_BIT]  = BYPASS_HIGH;

        // sense pin and external enables follow the effective code
        n.sense_drive = 1'b0;
        n.sense_chan  = r.sense_chan;
        n.standby     = 1'b0;
        n.ext_drv_diag_en0        = 1'b0;
        n.ext_drv_diag_en1        = 1'b0;
        case (route_t'(eff_sel))
            ROUTE_CH0, ROUTE_CH1, ROUTE_CH2, ROUTE_CH3: begin
                // an off channel leaves the pin undriven
                n.sense_drive = CHAN_ON[eff_sel[1:0]];
                n.sense_chan  = eff_sel[1:0];
            end
            ROUTE_EXT0: begin
                n.ext_drv_diag_en0 = 1'b1;
            end
            ROUTE_EXT1: begin
                n.ext_drv_diag_en0 = r.compat;
                n.ext_drv_diag_en1 = 1'b1;
            end
            ROUTE_HIZ: begin
                n.sense_drive = 1'b0;
            end
            ROUTE_STBY: begin
                n.standby = 1'b1;
            end
            default: begin
                n.sense_drive = 1'b0;
            end
        endcase
    end

    // state register, reset values from the package
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            r         <= '0;
            r.sense_route_select     <= route_t'(MUX_RST);
            r.src_on  <= SRC_ON_RST;
            r.auto_sw <= AUTO_RST;
            r.compat  <= COMPAT_RST;
            r.level   <= LEVEL_RST;
            r.sydel   <= {NUM_CH{SYDEL_RST}};
        end else begin
            r <= n;
        end
    end

    // ****************************************
    // per-channel sync delay
    // ****************************************
    for (genvar g = 0; g < NUM_CH; g++) begin : g_sync
        sync_delay u_dly (
            .clk      (CLK),
            .rst_n    (rst_n),
            .step_en  (PWM_CLK_EN),
            .sync_in  (SYNC_IN[g]),
            .sel      (r.sydel[g]),
            .sync_out (SYNC_OUT[g])
        );
    end

    // ****************************************
    // outputs, all from flops
    // ****************************************
    assign RD_DATA             = r.rd_data;
    assign RD_VALID            = r.rd_valid;
    assign DIAG_FRAME          = r.diag;
    assign SENSE_DRIVE         = r.sense_drive;
    assign SENSE_CHAN          = r.sense_chan;
    assign SENSE_STANDBY       = r.standby;
    assign EXT_DRV_DIAG_EN0    = r.ext_drv_diag_en0;
    assign EXT_DRV_DIAG_EN1    = r.ext_drv_diag_en1;
    assign OPEN_LOAD_SOURCE_ON = r.src_on;
    assign SOURCE_LEVEL_HIGH   = r.level;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!rst_n);

    sense_off_hiz_a: assert property (
        (!eff_sel[2] && !CHAN_ON[eff_sel[1:0]]) |=> !SENSE_DRIVE)
        else $error("sense pin driven for an off channel");

    sense_route_a: assert property (
        (!eff_sel[2] && CHAN_ON[eff_sel[1:0]])
        |=> (SENSE_DRIVE && SENSE_CHAN == $past(eff_sel[1:0])))
        else $error("sense of the selected channel not routed");

    edd_normal_a: assert property (
        (!r.compat && r.sense_route_select == ROUTE_EXT1)
        |=> (!EXT_DRV_DIAG_EN0 && EXT_DRV_DIAG_EN1))
        else $error("normal mode diag enables wrong for code 101");

    edd_compat_a: assert property (
        (r.compat && r.sense_route_select == ROUTE_EXT1) |=> (EXT_DRV_DIAG_EN0 && EXT_DRV_DIAG_EN1))
        else $error("compatibility diag enables wrong for code 101");

    standby_hiz_a: assert property (
        (r.sense_route_select == ROUTE_STBY) |=> (SENSE_STANDBY && !SENSE_DRIVE))
        else $error("stand-by code did not enter stand-by");

    bypass_read_a: assert property (
        (hit_dcr && !is_wr)
        |=> (RD_VALID && RD_DATA[BYPASS_BIT] == $past(BYPASS_HIGH)))
        else $error("bypass monitor not returned on read");

    source_write_a: assert property (
        (hit_dcr && is_wr) |=> (OPEN_LOAD_SOURCE_ON == $past(wdata[SRC_ON_BIT])))
        else $error("open-load source did not follow write");

    auto_route_a: assert property (
        (auto_act && CHAN_ON[AUTO_ROUTE_SEL])
        |=> (SENSE_DRIVE && SENSE_CHAN == $past(AUTO_ROUTE_SEL)))
        else $error("automatic sense routing not applied");

    fault_frame_a: assert property (
        ##1 (DIAG_FRAME[NUM_CH-1:0] == $past(CHAN_FAULT)))
        else $error("channel fault flags not in frame");

    level_write_a: assert property (
        (hit_input_drive_source_config && is_wr) |=> (SOURCE_LEVEL_HIGH == $past(wdata[LEVEL_BIT])))
        else $error("source level did not follow write");

    unused_zero_a: assert property (
        RD_VALID |-> (RD_DATA[DATA_W-1:AUTO_BIT+1] == '0))
        else $error("unused read bits not zero");

    edd_code0_a: assert property (
        (r.sense_route_select == ROUTE_EXT0) |=> (EXT_DRV_DIAG_EN0 && !EXT_DRV_DIAG_EN1))
        else $error("diag enables wrong for code 100");

    edd_idle_a: assert property (
        (r.sense_route_select[2:1] != 2'b10) |=> (!EXT_DRV_DIAG_EN0 && !EXT_DRV_DIAG_EN1))
        else $error("diag enable raised outside codes 100 and 101");

    hiz_code_a: assert property (
        (r.sense_route_select == ROUTE_HIZ) |=> (!SENSE_DRIVE && !SENSE_STANDBY))
        else $error("code 110 drove the sense pin");

    standby_only_a: assert property (
        (r.sense_route_select != ROUTE_STBY) |=> !SENSE_STANDBY)
        else $error("stand-by entered for another code");

    compat_read_a: assert property (
        (hit_input_drive_source_config && !is_wr) |=> (RD_DATA[COMPAT_BIT] == $past(r.compat)))
        else $error("compatibility bit not returned on read");

    delay_read_a: assert property (
        (hit_chan && !is_wr)
        |=> (RD_DATA[SYDEL_LSB +: 2] == $past(r.sydel[addr[1:0]])))
        else $error("sync delay field not returned on read");

    auto_hold_a: assert property (
        (!auto_act && !r.sense_route_select[2] && CHAN_ON[r.sense_route_select[1:0]])
        |=> (SENSE_DRIVE && SENSE_CHAN == $past(r.sense_route_select[1:0])))
        else $error("sense routing left the selected code");

    auto_write_a: assert property (
        (hit_dcr && is_wr) |=> (r.auto_sw == $past(wdata[AUTO_BIT])))
        else $error("automatic switching bit did not follow write");

    level_read_a: assert property (
        (hit_input_drive_source_config && !is_wr) |=> (RD_DATA[LEVEL_BIT] == $past(r.level)))
        else $error("source level bit not returned on read");

    cover_route_c: cover property (!eff_sel[2] && CHAN_ON[eff_sel[1:0]] ##1 SENSE_DRIVE);
    cover_compat_c: cover property (r.compat && r.sense_route_select == ROUTE_EXT0);
    cover_auto_c: cover property (auto_act ##1 SENSE_DRIVE);
    cover_stby_c: cover property (SENSE_STANDBY);
    cover_delay_c: cover property (r.sydel[0] == 2'h3 && SYNC_OUT[0]);

endmodule

// [testbench/frame_master.sv]
`timescale 1ns/100ps
module frame_master (
    input  wire logic   clk,
    output logic        frame_valid,
    output logic [15:0] frame_word
);
    // ****************************************
    // command word source, standing in for the serial master
    // ****************************************
    initial begin
        frame_valid = 1'b0;
        frame_word  = 16'h0000;
    end

    // one word per frame: raised after a falling edge, held across the taking edge
    task automatic xfer(input logic [15:0] w);
        @(negedge clk);
        frame_valid = 1'b1;
        frame_word  = w;
        @(negedge clk);
        frame_valid = 1'b0;
        frame_word  = ~w; // released bus shows no stale word, so a late sample is caught
    endtask
endmodule

// [testbench/diag_sense_ctrl_tb_top.sv]
`timescale 1ns/100ps
module diag_sense_ctrl_tb_top;
    import diag_sense_pkg::*;

    // ****************************************
    // stimulus and observed signals
    // ****************************************
    logic              CLK;
    logic              NRST;
    logic              FRAME_VALID;
    logic [15:0]       FRAME_WORD;
    logic [NUM_CH-1:0] CHAN_ON;
    logic              BYPASS_HIGH;
    logic [NUM_CH-1:0] CHAN_FAULT;
    logic              LIMP_HOME;
    logic              AUTO_PWM_RUN;
    logic [1:0]        AUTO_ROUTE_SEL;
    logic              PWM_CLK_EN = 1'b0;
    logic [NUM_CH-1:0] SYNC_IN;
    logic [DATA_W-1:0] RD_DATA;
    logic              RD_VALID;
    logic [15:0]       DIAG_FRAME;
    logic              SENSE_DRIVE;
    logic [1:0]        SENSE_CHAN;
    logic              SENSE_STANDBY;
    logic              EXT_DRV_DIAG_EN0;
    logic              EXT_DRV_DIAG_EN1;
    logic              OPEN_LOAD_SOURCE_ON;
    logic              SOURCE_LEVEL_HIGH;
    logic [NUM_CH-1:0] SYNC_OUT;
    logic [1:0]        pwm_cnt = 2'h0;
    logic [31:0]       r;
    logic [5:0]        e;
    int                fails;
    int                total_checks;
    int                cnt;

    diag_sense_ctrl i_diag_sense_ctrl (
        .CLK                 (CLK),
        .NRST                (NRST),
        .FRAME_VALID         (FRAME_VALID),
        .FRAME_WORD          (FRAME_WORD),
        .CHAN_ON             (CHAN_ON),
        .BYPASS_HIGH         (BYPASS_HIGH),
        .CHAN_FAULT          (CHAN_FAULT),
        .LIMP_HOME           (LIMP_HOME),
        .AUTO_PWM_RUN        (AUTO_PWM_RUN),
        .AUTO_ROUTE_SEL      (AUTO_ROUTE_SEL),
        .PWM_CLK_EN          (PWM_CLK_EN),
        .SYNC_IN             (SYNC_IN),
        .RD_DATA             (RD_DATA),
        .RD_VALID            (RD_VALID),
        .DIAG_FRAME          (DIAG_FRAME),
        .SENSE_DRIVE         (SENSE_DRIVE),
        .SENSE_CHAN          (SENSE_CHAN),
        .SENSE_STANDBY       (SENSE_STANDBY),
        .EXT_DRV_DIAG_EN0    (EXT_DRV_DIAG_EN0),
        .EXT_DRV_DIAG_EN1    (EXT_DRV_DIAG_EN1),
        .OPEN_LOAD_SOURCE_ON (OPEN_LOAD_SOURCE_ON),
        .SOURCE_LEVEL_HIGH   (SOURCE_LEVEL_HIGH),
        .SYNC_OUT            (SYNC_OUT)
    );

    frame_master i_frame_master (
        .clk         (CLK),
        .frame_valid (FRAME_VALID),
        .frame_word  (FRAME_WORD)
    );

    // ****************************************
    // clock and reference pulse, one pulse every four cycles
    // ****************************************
    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end

    always @(negedge CLK) begin
        pwm_cnt    <= pwm_cnt + 2'h1;
        PWM_CLK_EN <= (pwm_cnt == 2'h3);
    end

    // ****************************************
    // comparison, bus tasks and expectation
    // ****************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] addr, input logic [9:0] data);
        i_frame_master.xfer({1'b1, REG_BANK, addr, data});
    endtask

    // answer stands one cycle only, so it is looked at on the first falling edge after taking
    task automatic rd(input logic [3:0] addr, input logic [9:0] exp);
        i_frame_master.xfer({1'b0, REG_BANK, addr, 10'h000});
        check({15'h0000, RD_VALID}, 16'h0001);
        check({6'h00, RD_DATA}, {6'h00, exp});
    endtask

    // {drive, channel, stand-by, enable 0, enable 1} for one selector setting
    function automatic logic [5:0] exp_sense(input logic [2:0] sense_route_select, input logic compat,
                                             input logic [3:0] on, input logic auto_sw,
                                             input logic run, input logic [1:0] asel);
        logic [1:0] ch;
        ch = (auto_sw && run && !sense_route_select[2]) ? asel : sense_route_select[1:0];
        case (sense_route_select)
            3'h4:    exp_sense = {1'b0, 2'h0, 1'b0, 1'b1, 1'b0};
            3'h5:    exp_sense = {1'b0, 2'h0, 1'b0, compat, 1'b1};
            3'h6:    exp_sense = 6'h00;
            3'h7:    exp_sense = {1'b0, 2'h0, 1'b1, 2'h0};
            default: exp_sense = {on[ch], ch, 3'h0};
        endcase
    endfunction

    task automatic conclude();
        if (fails == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ****************************************
    // watchdog: the whole sequence needs well under 10000 cycles
    // ****************************************
    initial begin
        #200000;
        fails++;
        conclude();
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        fails          = 0;
        total_checks   = 0;
        NRST           = 1'b0;
        CHAN_ON        = 4'h0;
        BYPASS_HIGH    = 1'b1;
        CHAN_FAULT     = 4'h0;
        LIMP_HOME      = 1'b0;
        AUTO_PWM_RUN   = 1'b0;
        AUTO_ROUTE_SEL = 2'h0;
        SYNC_IN        = 4'h0;
        void'($urandom(62197));
        repeat (6) @(negedge CLK);
        NRST = 1'b1;
        repeat (3) @(negedge CLK);
        check({15'h0000, SENSE_DRIVE}, 16'h0000);
        rd(ADDR_DIAG_CTRL, {5'h00, AUTO_RST, BYPASS_HIGH, MUX_RST});
        // bank 0 write must leave everything alone, an unknown address reads zero
        i_frame_master.xfer({1'b1, ~REG_BANK, ADDR_DIAG_CTRL, 10'h01F});
        rd(ADDR_DIAG_CTRL, {5'h00, AUTO_RST, BYPASS_HIGH, MUX_RST});
        check({15'h0000, OPEN_LOAD_SOURCE_ON}, 16'h0000);
        rd(4'h2, 10'h000);
        // every selector code in both drive modes, with random levels and junk in bits 9:5
        for (int i = 0; i < 48; i++) begin
            r              = $urandom;
            CHAN_ON        = r[3:0];
            BYPASS_HIGH    = r[4];
            AUTO_PWM_RUN   = r[5];
            AUTO_ROUTE_SEL = r[7:6];
            CHAN_FAULT     = r[11:8];
            LIMP_HOME      = r[12];
            wr(ADDR_IN_DRIVE, {8'h00, r[14], i[3]});
            wr(ADDR_DIAG_CTRL, {r[19:15], r[20], r[21], i[2:0]});
            @(negedge CLK);
            e = exp_sense(i[2:0], i[3], r[3:0], r[20], r[5], r[7:6]);
            check({12'h000, SENSE_DRIVE, e[5] ? SENSE_CHAN : e[4:3], SENSE_STANDBY},
                  {12'h000, e[5:2]});
            check({14'h0000, EXT_DRV_DIAG_EN0, EXT_DRV_DIAG_EN1},
                  {14'h0000, e[1:0]});
            check({15'h0000, OPEN_LOAD_SOURCE_ON}, {15'h0000, r[21]});
            check({15'h0000, SOURCE_LEVEL_HIGH}, {15'h0000, r[14]});
            check(DIAG_FRAME, {1'b0, r[12], r[4], 9'h000, r[11:8]});
            rd(ADDR_DIAG_CTRL, {5'h00, r[20], r[4], i[2:0]});
            rd(ADDR_IN_DRIVE, {8'h00, r[14], i[3]});
        end
        // delay codes per channel: count reference pulses until the delayed copy rises
        for (int n = 0; n < NUM_CH; n++) begin
            for (int c = 0; c < 4; c++) begin
                wr({ADDR_CHAN_HI, 2'(n)}, {6'h00, 2'(c), 2'h0});
                rd({ADDR_CHAN_HI, 2'(n)}, {6'h00, 2'(c), 2'h0});
                SYNC_IN[n] = 1'b1;
                cnt = 0;
                // pulses counted at the taking edge, the output looked at once it has settled
                for (int k = 0; k < 200 && SYNC_OUT[n] !== 1'b1; k++) begin
                    @(posedge CLK);
                    if (PWM_CLK_EN === 1'b1) cnt++;
                    @(negedge CLK);
                end
                check({15'h0000, (cnt >= 8 * c && cnt <= 8 * c + 1)}, 16'h0001);
                @(negedge CLK);
                SYNC_IN[n] = 1'b0;
                repeat (120) @(negedge CLK);
            end
        end
        conclude();
    end
endmodule
